// *** dv/cmt_asserts.sv ***
`timescale 1ns/1ps
module cmt_asserts
  import cmt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cmt_mem_out_t mem_out,
  input wire cmt_owner_t bus_owner,
  input wire logic dma_req,
  input wire logic [ADDR_W-1:0] physical_cpu_address,
  input wire logic [ADDR_W-1:0] io_address_bus,
  input wire logic [DATA_W-1:0] cpu_internal_bus_i,
  input wire logic io_request,
  input wire logic [IOCOPY_W-1:0] io_instr_copy,
  input wire logic memory_data_bus_oe_n,
  input wire logic multiport_request,
  input wire logic multiport_write,
  input wire logic multiport_data_oe_n,
  input wire logic io_data_bus_oe_n,
  input wire logic irq_level14,
  input wire logic cpu_internal_error
);
  logic [10:0] ins_lo;
  logic [9:0] rq_q;
  assign ins_lo = cpu_internal_bus_i[10:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rq_q <= '0;
    else rq_q <= mem_out.req ? rq_q + 10'h1 : 10'h0;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_dma_first: assert property ($rose(mem_out.req) && $past(dma_req) |-> bus_owner == OWN_DMA)
    else $error("dma not granted first");
  a_cpu_addr: assert property ($rose(mem_out.req) && bus_owner == OWN_CPU
    |-> mem_out.addr == $past(physical_cpu_address)) else $error("cpu address wrong");
  a_dma_addr: assert property ($rose(mem_out.req) && bus_owner == OWN_DMA
    |-> mem_out.addr == $past(io_address_bus)) else $error("dma address wrong");
  a_tmo_bound: assert property (rq_q <= 10'd620) else $error("request outlived timeout");
  a_err_pulse: assert property (cpu_internal_error |=> !cpu_internal_error)
    else $error("internal error not a pulse");
  a_irq_pulse: assert property ($rose(irq_level14) |=> $fell(irq_level14))
    else $error("irq not a pulse");
  a_io_copy: assert property ($rose(io_request) |-> io_instr_copy == $past(ins_lo))
    else $error("instruction copy wrong");
  a_mp_gate: assert property (multiport_request |-> mem_out.req && bus_owner != OWN_NONE)
    else $error("multiport request outside cycle");
  a_wr_drive: assert property (!memory_data_bus_oe_n |-> mem_out.write)
    else $error("data driven on read");
  a_mp_write: assert property (multiport_write |-> multiport_request && mem_out.write)
    else $error("multiport write outside cycle");
  a_mp_data: assert property (!multiport_data_oe_n |-> multiport_write)
    else $error("multiport data driven outside range");
  a_io_drive: assert property (!io_data_bus_oe_n |-> io_request)
    else $error("io data driven outside transfer");
  c_dma: cover property ($rose(mem_out.req) && bus_owner == OWN_DMA);
  c_tmo: cover property (cpu_internal_error);
  c_irq: cover property (irq_level14);
  c_io: cover property ($rose(io_request));
endmodule : cmt_asserts
bind cmt_transceiver cmt_asserts chk_u (.hclk, .hresetn, .hreadyout, .hresp, .mem_out,
  .bus_owner, .dma_req, .physical_cpu_address, .io_address_bus, .cpu_internal_bus_i,
  .io_request, .io_instr_copy, .memory_data_bus_oe_n, .multiport_request, .multiport_write,
  .multiport_data_oe_n, .io_data_bus_oe_n, .irq_level14, .cpu_internal_error);

// *** dv/cmt_mem_model.sv ***
`timescale 1ns/1ps
module cmt_mem_model
  import cmt_pkg::*;
(
  input wire logic hclk,
  input wire cmt_mem_out_t mem_out,
  input wire logic multiport_request,
  input wire logic [3:0] dly,
  input wire logic [15:0] err,
  input wire logic mute,
  input wire logic io_request,
  output logic mem_data_ready,
  output logic multiport_data_ready,
  output logic [DATA_W-1:0] memory_data_bus_i = '0,
  output logic [CHK_W-1:0] mem_check_i = '0,
  output logic io_connect = 1'b0
);
  logic [21:0] mem [256];
  logic [3:0] cnt = '0;
  logic rdy = 1'b0;
  initial for (int k = 0; k < 256; k++) mem[k] = '0;
  // ready goes back on the port that made the request
  assign mem_data_ready = rdy & ~multiport_request;
  assign multiport_data_ready = rdy & multiport_request;
  always @(posedge hclk) begin
    // counter sticks at its top so ready holds until the request drops
    cnt <= (mem_out.req | io_request) ? cnt + 4'(cnt != 4'hf) : 4'h0;
    rdy <= mem_out.req && cnt >= dly && !mute;
    io_connect <= io_request && cnt >= dly && !mute;
    if (rdy && mem_out.write) mem[mem_out.addr[7:0]] <= {mem_out.check, mem_out.wdata};
    // released lines toggle so a stale value is never mistaken for data
    if (rdy && !mem_out.write) {mem_check_i, memory_data_bus_i} <= mem[mem_out.addr[7:0]] ^ err;
    else {mem_check_i, memory_data_bus_i} <= ~{mem_check_i, memory_data_bus_i};
  end
endmodule : cmt_mem_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  import cmt_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic cpu_mem_req = 0, cpu_mem_write = 0, cpu_fetch = 0, dma_req = 0, dma_write = 0;
  logic dma_via_cpu = 1, dma_local = 1, refresh_req = 0, io_req = 0, io_dir_in = 0;
  logic cpu_instr_present = 0, cpu_data_present = 0, panel_latch_write = 0, mute = 0;
  logic cpu_internal_bus_oe_n, io_data_bus_oe_n, io_request, io_connect, multiport_write;
  logic memory_data_bus_oe_n, mem_data_ready, multiport_request, multiport_data_oe_n;
  logic multiport_data_ready, multiport_address_ready = 0, irq_level14, cpu_internal_error;
  logic [ADDR_W-1:0] physical_cpu_address = 0, io_address_bus = 0, lamp_addr, a;
  logic [DATA_W-1:0] cpu_internal_bus_i = 0, cpu_internal_bus_o, io_data_bus_i = 0;
  logic [DATA_W-1:0] io_data_bus_o, memory_data_bus_i, lamp_data, err = 0, d;
  logic [15:0] lamp_addr_decode, lamp_level_decode, exp_q[$];
  logic [IOCOPY_W-1:0] io_instr_copy;
  logic [CHK_W-1:0] mem_check_i;
  logic [3:0] active_level_bits = 0, dly = 0;
  cmt_mem_out_t mem_out;
  cmt_owner_t bus_owner;
  cmt_buttons_t buttons = '0;
  int bad_count = 0, compares = 0, irqs = 0, errs = 0, mps = 0, i;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  cmt_transceiver dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .cpu_mem_req, .cpu_mem_write, .cpu_fetch,
    .physical_cpu_address, .dma_req, .dma_write, .dma_via_cpu, .dma_local, .refresh_req,
    .io_req, .io_dir_in, .cpu_instr_present, .cpu_data_present, .panel_latch_write,
    .io_address_bus, .cpu_internal_bus_i, .cpu_internal_bus_o, .cpu_internal_bus_oe_n,
    .io_data_bus_i, .io_data_bus_o, .io_data_bus_oe_n, .io_request, .io_connect,
    .io_instr_copy, .mem_out, .memory_data_bus_oe_n, .memory_data_bus_i, .mem_check_i,
    .mem_data_ready, .multiport_request, .multiport_write, .multiport_data_oe_n,
    .multiport_data_ready, .multiport_address_ready, .bus_owner, .irq_level14,
    .cpu_internal_error, .buttons, .active_level_bits, .lamp_addr, .lamp_data,
    .lamp_addr_decode, .lamp_level_decode);
  cmt_mem_model mdl_u (.hclk, .mem_out, .multiport_request, .dly, .err, .mute, .io_request,
    .mem_data_ready, .multiport_data_ready, .memory_data_bus_i, .mem_check_i, .io_connect);
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task hang;
    bad_count++;
    $display("Error %0t wait ran out", $time);
    give_verdict();
  endtask : hang
  task hedge;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1 && i < 9);
    if (i == 9) hang();
  endtask : hedge
  task ahb(input logic w, input logic [7:0] o, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, o};
    hedge();
    htrans <= 2'h0;
    hwdata <= wd;
    hedge();
    rd = hrdata;
  endtask : ahb
  // s selects the handshake: 0 memory request, 1 i/o request
  task wsig(input logic s, input logic v);
    for (i = 0; (s ? io_request : mem_out.req) !== v; i++) begin
      if (i == 800) hang();
      @(posedge hclk);
    end
  endtask : wsig
  task mem_op(input logic w, input logic f, input logic [17:0] ad, input logic [15:0] dd);
    cpu_mem_req <= 1;
    cpu_mem_write <= w;
    cpu_fetch <= f;
    physical_cpu_address <= ad;
    cpu_internal_bus_i <= dd;
    @(posedge hclk);
    // the error pattern is settled only after this edge
    if (!w && $countones(err) < 2) exp_q.push_back(dd);
    wsig(0, 1);
    cpu_mem_req <= 0;
    wsig(0, 0);
    repeat (4) @(posedge hclk);
  endtask : mem_op
  task io_op(input logic din, input logic [15:0] dd);
    io_req <= 1;
    io_dir_in <= din;
    cpu_internal_bus_i <= dd;
    io_data_bus_i <= ~dd;
    if (din && !mute) exp_q.push_back(~dd);
    @(posedge hclk);
    wsig(1, 1);
    chk(io_instr_copy, dd[10:0]);
    if (!din && !mute) chk(io_data_bus_o, dd);
    io_req <= 0;
    wsig(1, 0);
    repeat (4) @(posedge hclk);
  endtask : io_op
  always @(posedge hclk) begin
    if (irq_level14 === 1) irqs++;
    if (cpu_internal_error === 1) errs++;
    if (multiport_request === 1) mps++;
    if (cpu_internal_bus_oe_n === 0 && exp_q.size() > 0) chk(cpu_internal_bus_o, exp_q.pop_front());
  end
  initial begin
    void'($urandom(68010));
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    ahb(0, OFS_ECC_CTRL, 0);
    chk(rd, {29'h0, ECC_CTRL_RST});
    ahb(0, OFS_LIMIT_HI, 0);
    chk(rd, {14'h0, LIMIT_HI_RST});
    ahb(1, 8'h40, 32'hffff);
    ahb(0, 8'h40, 0);
    chk(rd, 0);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      ahb(1, OFS_ECC_CTRL, m);
      a = 18'($urandom) & 18'h0efff;
      d = 16'($urandom);
      dly = 4'($urandom);
      mem_op(1, 0, a, d);
      mem_op(0, m == 2, a, d);
    end
    buttons <= 8'h80;
    repeat (2) @(posedge hclk);
    chk(lamp_addr, a);
    buttons <= 8'h01;
    repeat (3) @(posedge hclk);
    chk(lamp_addr_decode[a[15:12]], 1);
    buttons <= 8'h02;
    active_level_bits <= 4'h5;
    repeat (3) @(posedge hclk);
    chk(lamp_level_decode[5], 1);
    $display("test memory done");
    ahb(1, OFS_ECC_CTRL, 0);
    mem_op(1, 0, a, d);
    err <= 16'h0010;
    mem_op(0, 0, a, d);
    chk(irqs, 0);
    ahb(0, OFS_ERR_STAT, 0);
    chk(rd[ST_SINGLE], 1);
    chk(rd[14:9], 6'h29);
    ahb(0, OFS_ERR_ADDR, 0);
    chk(rd, a);
    ahb(1, OFS_ERR_STAT, 32'hffff);
    ahb(1, OFS_ECC_CTRL, 4);
    mem_op(0, 0, a, d);
    chk(irqs, 1);
    err <= 16'h0003;
    mem_op(0, 0, a, d);
    chk(irqs, 2);
    ahb(0, OFS_ERR_STAT, 0);
    chk(rd[ST_MULTI], 1);
    err <= 0;
    $display("test correction done");
    io_address_bus <= 18'($urandom);
    dma_req <= 1;
    refresh_req <= 1;
    cpu_mem_req <= 1;
    cpu_mem_write <= 1;
    for (int k = 0; k < 3; k++) begin
      wsig(0, 1);
      chk(bus_owner, k + 1);
      if (k == 0) dma_req <= 0;
      if (k == 1) refresh_req <= 0;
      if (k == 2) cpu_mem_req <= 0;
      wsig(0, 0);
    end
    buttons <= 8'h20;
    repeat (2) @(posedge hclk);
    chk(lamp_addr, io_address_bus);
    buttons <= 8'h40;
    repeat (2) @(posedge hclk);
    chk(lamp_addr, a);
    $display("test priority done");
    for (int k = 0; k < 3; k++) begin
      {cpu_instr_present, cpu_data_present, panel_latch_write} <= 3'h4 >> k;
      cpu_internal_bus_i <= 16'h1234 + k;
      @(posedge hclk);
      {cpu_instr_present, cpu_data_present, panel_latch_write} <= 3'h0;
      buttons <= 8'h10 >> k;
      repeat (2) @(posedge hclk);
      chk(lamp_data, 16'h1234 + k);
    end
    io_op(0, 16'($urandom));
    io_op(1, 16'($urandom));
    $display("test io done");
    ahb(1, OFS_CONFIG, 1);
    ahb(1, OFS_LIMIT_LO, 32'h100);
    ahb(1, OFS_LIMIT_HI, 32'h1ff);
    mps = 0;
    mem_op(1, 0, 18'h00050, d);
    chk(mps, 0);
    mem_op(1, 0, 18'h00150, d);
    chk(mps > 0, 1);
    $display("test range done");
    mute <= 1;
    mem_op(1, 0, a, d);
    chk(errs, 1);
    io_op(0, 16'h07ff);
    chk(errs, 2);
    ahb(0, OFS_ERR_STAT, 0);
    chk(rd[ST_IO_TMO:ST_MEM_TMO], 2'h3);
    $display("test timeout done");
    give_verdict();
  end
endmodule : tb

// *** hw/cmt_transceiver.sv ***
`timescale 1ns/1ps
module cmt_transceiver
  import cmt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_mem_req,
  input wire logic cpu_mem_write,
  input wire logic cpu_fetch,
  input wire logic [ADDR_W-1:0] physical_cpu_address,
  input wire logic dma_req,
  input wire logic dma_write,
  input wire logic dma_via_cpu,
  input wire logic dma_local,
  input wire logic refresh_req,
  input wire logic io_req,
  input wire logic io_dir_in,
  input wire logic cpu_instr_present,
  input wire logic cpu_data_present,
  input wire logic panel_latch_write,
  input wire logic [ADDR_W-1:0] io_address_bus,
  input wire logic [DATA_W-1:0] cpu_internal_bus_i,
  output logic [DATA_W-1:0] cpu_internal_bus_o,
  output logic cpu_internal_bus_oe_n,
  input wire logic [DATA_W-1:0] io_data_bus_i,
  output logic [DATA_W-1:0] io_data_bus_o,
  output logic io_data_bus_oe_n,
  output logic io_request,
  input wire logic io_connect,
  output logic [IOCOPY_W-1:0] io_instr_copy,
  output cmt_mem_out_t mem_out,
  output logic memory_data_bus_oe_n,
  input wire logic [DATA_W-1:0] memory_data_bus_i,
  input wire logic [CHK_W-1:0] mem_check_i,
  input wire logic mem_data_ready,
  output logic multiport_request,
  output logic multiport_write,
  output logic multiport_data_oe_n,
  input wire logic multiport_data_ready,
  input wire logic multiport_address_ready,
  output cmt_owner_t bus_owner,
  output logic irq_level14,
  output logic cpu_internal_error,
  input wire cmt_buttons_t buttons,
  input wire logic [3:0] active_level_bits,
  output logic [ADDR_W-1:0] lamp_addr,
  output logic [DATA_W-1:0] lamp_data,
  output logic [15:0] lamp_addr_decode,
  output logic [15:0] lamp_level_decode
);
  cmt_state_t q, d;

  function automatic logic [4:0] ham(input logic [DATA_W-1:0] dat);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (dat[i]) c = c ^ CHK_POS[i];
    end
    return c;
  endfunction : ham

  logic [4:0] wr_ham, rd_ham, synd;
  logic [CHK_W-1:0] wr_chk, rd_full;
  logic rd_par, err_single, err_multi, in_range, done_mem, done_io, tmo_hit, link_quiet;
  logic [DATA_W-1:0] corrected;
  logic [31:0] reg_rd;

  always_comb begin
    // check bits for the word being written
    wr_ham = ham(q.wdata);
    wr_chk = {^{q.wdata, wr_ham}, wr_ham};
    case (q.ecc_ctrl[1:0])
      MODE_LOCAL21: wr_chk[5] = 1'b0;
      MODE_MULTIPORT: wr_chk[3:0] = 4'h0;
      default: ;
    endcase
  end

  always_comb begin
    rd_ham = ham(memory_data_bus_i);
    rd_full = {^{memory_data_bus_i, rd_ham}, rd_ham};
    synd = mem_check_i[4:0] ^ rd_ham;
    rd_par = ^{memory_data_bus_i, mem_check_i};
    err_single = 1'b0;
    err_multi = 1'b0;
    case (q.ecc_ctrl[1:0])
      MODE_LOCAL21: err_single = synd != 5'h00;
      MODE_MULTIPORT: err_multi = mem_check_i[5:4] != rd_full[5:4];
      default: begin
        err_single = rd_par;
        err_multi = !rd_par && synd != 5'h00;
      end
    endcase
    corrected = memory_data_bus_i;
    for (int i = 0; i < DATA_W; i++) begin
      if (err_single && synd == CHK_POS[i]) corrected[i] = ~memory_data_bus_i[i];
    end
  end

  // multiport range gate; without local memory everything goes to multiport
  assign in_range = !q.both_fitted || (q.addr >= q.lim_lo && q.addr <= q.lim_hi);
  assign done_mem = q.st == ST_MEM && q.rdy_s[1];
  assign done_io = q.st == ST_IO && q.con_s[1];
  assign tmo_hit = q.st != ST_IDLE && q.tmo == TMO_W'(TIMEOUT_CYC - 1);
  // a new cycle waits until the last answer has left the synchronisers
  assign link_quiet = !q.rdy_s[1] && !q.con_s[1];

  always_comb begin
    reg_rd = 32'h00000000;
    case (q.a_ofs)
      OFS_ECC_CTRL: reg_rd[2:0] = q.ecc_ctrl;
      OFS_ERR_STAT: reg_rd[15:0] = q.err_stat;
      OFS_ERR_ADDR: reg_rd[ADDR_W-1:0] = q.err_addr;
      OFS_LIMIT_LO: reg_rd[ADDR_W-1:0] = q.lim_lo;
      OFS_LIMIT_HI: reg_rd[ADDR_W-1:0] = q.lim_hi;
      OFS_CONFIG: reg_rd[0] = q.both_fitted;
      default: ;
    endcase
  end

  always_comb begin
    d = q;
    d.irq14 = 1'b0;
    d.int_err = 1'b0;
    d.rvalid = 1'b0;
    d.rdy_s = {q.rdy_s[0], mem_data_ready | multiport_data_ready};
    d.con_s = {q.con_s[0], io_connect};
    // bus slave: capture address phase, act in the data phase
    d.a_wr = hsel && hready && htrans[1] && hwrite;
    d.a_rd = hsel && hready && htrans[1] && !hwrite;
    if (hsel && hready) d.a_ofs = haddr[7:0];
    if (q.a_wr) begin
      case (q.a_ofs)
        OFS_ECC_CTRL: d.ecc_ctrl = hwdata[2:0];
        OFS_ERR_STAT: d.err_stat = q.err_stat & ~hwdata[15:0];
        OFS_LIMIT_LO: d.lim_lo = hwdata[ADDR_W-1:0];
        OFS_LIMIT_HI: d.lim_hi = hwdata[ADDR_W-1:0];
        OFS_CONFIG: d.both_fitted = hwdata[0];
        default: ;
      endcase
    end
    case (q.st)
      ST_IDLE: begin
        d.tmo = '0;
        if (dma_req && link_quiet) begin
          d.st = ST_MEM;
          d.own = OWN_DMA;
          d.mwr = dma_write;
          d.addr = io_address_bus;
          d.wdata = io_data_bus_i;
          if (dma_local) d.lat_dma = io_address_bus;
        end else if (refresh_req && link_quiet) begin
          d.st = ST_MEM;
          d.own = OWN_REFRESH;
          d.mwr = 1'b0;
          d.addr = ADDR_W'(q.rfsh);
          d.rfsh = q.rfsh + 1'b1;
        end else if (cpu_mem_req && link_quiet) begin
          d.st = ST_MEM;
          d.own = OWN_CPU;
          d.mwr = cpu_mem_write;
          d.fetch = cpu_fetch;
          d.addr = physical_cpu_address;
          d.wdata = cpu_internal_bus_i;
          if (cpu_fetch) d.lat_fetch = physical_cpu_address;
          else d.lat_oper = physical_cpu_address;
        end else if (io_req && link_quiet) begin
          d.st = ST_IO;
          d.io_in = io_dir_in;
          d.wdata = cpu_internal_bus_i;
          d.iocopy = cpu_internal_bus_i[IOCOPY_W-1:0];
        end
      end
      ST_MEM: begin
        d.tmo = q.tmo + 1'b1;
        if (done_mem) begin
          d.st = ST_IDLE;
          d.own = OWN_NONE;
          if (!q.mwr) begin
            d.rdata = corrected;
            d.rvalid = q.own == OWN_CPU;
            if (err_single || err_multi) begin
              d.err_stat[ST_SYND_LO +: CHK_W] = mem_check_i ^ rd_full;
              d.err_addr = q.addr;
            end
            if (err_single) d.err_stat[ST_SINGLE] = 1'b1;
            if (err_multi) d.err_stat[ST_MULTI] = 1'b1;
            d.irq14 = err_multi || (err_single && q.ecc_ctrl[ECC_SINGLE_IRQ_BIT]);
          end
        end else if (tmo_hit) begin
          d.st = ST_IDLE;
          d.own = OWN_NONE;
          d.err_stat[ST_MEM_TMO] = 1'b1;
          d.err_addr = q.addr;
          d.int_err = 1'b1;
        end
      end
      ST_IO: begin
        d.tmo = q.tmo + 1'b1;
        if (done_io) begin
          d.st = ST_IDLE;
          d.rdata = io_data_bus_i;
          d.rvalid = q.io_in;
        end else if (tmo_hit) begin
          d.st = ST_IDLE;
          d.err_stat[ST_IO_TMO] = 1'b1;
          d.int_err = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // panel word latches
    if (cpu_instr_present) d.lat_instr = cpu_internal_bus_i;
    if (cpu_data_present) d.lat_data = cpu_internal_bus_i;
    if (panel_latch_write) d.lat_panel = cpu_internal_bus_i;
    // decoders hold their lines while the button is down
    d.dec_addr = 16'h0001 << q.addr[15:12];
    if (buttons.decode_addr) d.dec_addr = q.dec_addr | (16'h0001 << q.addr[15:12]);
    d.dec_level = 16'h0001 << active_level_bits;
    if (buttons.active_level) d.dec_level = q.dec_level | (16'h0001 << active_level_bits);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.own <= OWN_NONE;
      q.ecc_ctrl <= ECC_CTRL_RST;
      q.lim_lo <= LIMIT_LO_RST;
      q.lim_hi <= LIMIT_HI_RST;
    end else begin
      q <= d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.a_rd ? reg_rd : 32'h00000000;

  assign bus_owner = q.own;
  assign mem_out.addr = q.addr;
  assign mem_out.wdata = q.wdata;
  assign mem_out.check = wr_chk;
  assign mem_out.req = q.st == ST_MEM;
  assign mem_out.write = q.st == ST_MEM && q.mwr;
  assign memory_data_bus_oe_n = !(q.st == ST_MEM && q.mwr);
  assign multiport_request = q.st == ST_MEM && in_range;
  assign multiport_write = q.st == ST_MEM && q.mwr && in_range;
  assign multiport_data_oe_n = !(q.st == ST_MEM && q.mwr && in_range);

  // read data go back on the CPU bus only, for CPU memory reads and i/o input; DMA read data are not returned
  assign cpu_internal_bus_o = q.rdata;
  assign cpu_internal_bus_oe_n = !(q.rvalid && q.own != OWN_DMA);
  assign io_data_bus_o = q.wdata;
  assign io_data_bus_oe_n = !(q.st == ST_IO && !q.io_in);
  assign io_request = q.st == ST_IO;
  assign io_instr_copy = q.iocopy;
  assign irq_level14 = q.irq14;
  assign cpu_internal_error = q.int_err;

  always_comb begin
    lamp_addr = q.lat_oper;
    if (buttons.prog_addr) lamp_addr = q.lat_fetch;
    else if (buttons.dma_addr) lamp_addr = q.lat_dma;
    lamp_data = q.lat_panel;
    if (buttons.instr) lamp_data = q.lat_instr;
    else if (buttons.data) lamp_data = q.lat_data;
  end

  assign lamp_addr_decode = q.dec_addr;
  assign lamp_level_decode = q.dec_level;
endmodule : cmt_transceiver

// *** shared/cmt_pkg.sv ***
package cmt_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CHK_W = 6;
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 6;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TMO_W = 10;
  localparam int IOCOPY_W = 11;
  localparam int REFRESH_W = 7;
  // register byte offsets
  localparam logic [7:0] OFS_ECC_CTRL = 8'h00;
  localparam logic [7:0] OFS_ERR_STAT = 8'h04;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h08;
  localparam logic [7:0] OFS_LIMIT_LO = 8'h0c;
  localparam logic [7:0] OFS_LIMIT_HI = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  // error correction control fields
  localparam int ECC_SINGLE_IRQ_BIT = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_LOCAL21 = 2'h1;
  localparam logic [1:0] MODE_MULTIPORT = 2'h2;
  // error status fields
  localparam int ST_SINGLE = 0;
  localparam int ST_MULTI = 1;
  localparam int ST_MEM_TMO = 3;
  localparam int ST_IO_TMO = 4;
  localparam int ST_SYND_LO = 9;
  // reset values
  localparam logic [2:0] ECC_CTRL_RST = 3'h0;
  localparam logic [17:0] LIMIT_LO_RST = 18'h00000;
  localparam logic [17:0] LIMIT_HI_RST = 18'h3ffff;
  // hamming positions of data bits 0..15 (bit 15 first)
  localparam logic [15:0][4:0] CHK_POS = {5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h0f,
    5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h07, 5'h06, 5'h05, 5'h03};

  typedef enum logic [1:0] {OWN_NONE, OWN_DMA, OWN_REFRESH, OWN_CPU} cmt_owner_t;
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_IO} cmt_fsm_t;

  typedef struct packed {
    logic prog_addr;
    logic addr;
    logic dma_addr;
    logic instr;
    logic data;
    logic reg_or_examine;
    logic active_level;
    logic decode_addr;
  } cmt_buttons_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [CHK_W-1:0] check;
    logic req;
    logic write;
  } cmt_mem_out_t;

  typedef struct packed {
    cmt_fsm_t st;
    cmt_owner_t own;
    logic [TMO_W-1:0] tmo;
    logic mwr;
    logic fetch;
    logic io_in;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [REFRESH_W-1:0] rfsh;
    logic [1:0] rdy_s;
    logic [1:0] con_s;
    logic a_wr;
    logic a_rd;
    logic [7:0] a_ofs;
    logic [2:0] ecc_ctrl;
    logic [15:0] err_stat;
    logic [ADDR_W-1:0] err_addr;
    logic [ADDR_W-1:0] lim_lo;
    logic [ADDR_W-1:0] lim_hi;
    logic both_fitted;
    logic [ADDR_W-1:0] lat_fetch;
    logic [ADDR_W-1:0] lat_oper;
    logic [ADDR_W-1:0] lat_dma;
    logic [DATA_W-1:0] lat_instr;
    logic [DATA_W-1:0] lat_data;
    logic [DATA_W-1:0] lat_panel;
    logic [15:0] dec_addr;
    logic [15:0] dec_level;
    logic [IOCOPY_W-1:0] iocopy;
    logic irq14;
    logic int_err;
  } cmt_state_t;
endpackage : cmt_pkg
